// ---- hw/sctf_pkg.sv ----
// Constants, cell layout and register map of the switch cell tx formatter.
// Assumes a single 20 MHz clock domain and a 32-bit AXI4-Lite register bus.
package sctf_pkg;
  // ==========================================================================
  // Cell layout
  localparam int          CELL_WORDS  = 16;
  localparam int          FIFO_WORDS  = 32;
  localparam logic [3:0]  WORD_LAST   = 4'hF;
  localparam logic [3:0]  IDLE_HDR_W  = 4'h2;
  localparam logic [1:0]  LANE_MASTER = 2'h1;
  localparam logic [7:0]  IDLE_FILL   = 8'hCC;
  localparam logic [7:0]  SYNC_FILL   = 8'hA5;
  localparam logic [7:0]  CRC_SEED    = 8'hD0;
  localparam logic [7:0]  CRC_POLY    = 8'h1D;
  localparam logic [1:0]  QUAL_IDLE   = 2'h0;
  localparam logic [1:0]  QUAL_DATA   = 2'h3;
  localparam int          QUAL_PAR    = 6;
  localparam int          CH_BYTES    = 6;
  // ==========================================================================
  // Frame header layout
  localparam int          FH_BYTES    = 10;
  localparam logic [5:0]  FH_BASE [4] = '{6'h06, 6'h10, 6'h20, 6'h30};
  localparam logic [5:0]  QT_BYTE     = 6'h04;
  localparam logic [3:0]  FC_ALL_ONES = 4'hF;
  localparam int          FH_UC_BIT   = 7;
  localparam logic [5:0]  CORR_FULL   = 6'h3F;
  // Logical byte index per (word, lane); lane 0 is link_lane_out bits 7:0
  localparam logic [5:0]  LANE_MAP [64] = '{
    6'd5,  6'd0,  6'd15, 6'd13, 6'd6,  6'd1,  6'd10, 6'd8,
    6'd7,  6'd2,  6'd11, 6'd9,  6'd4,  6'd3,  6'd14, 6'd12,
    6'd31, 6'd29, 6'd27, 6'd25, 6'd18, 6'd16, 6'd22, 6'd20,
    6'd19, 6'd17, 6'd23, 6'd21, 6'd30, 6'd28, 6'd26, 6'd24,
    6'd47, 6'd45, 6'd43, 6'd41, 6'd34, 6'd32, 6'd38, 6'd36,
    6'd35, 6'd33, 6'd39, 6'd37, 6'd46, 6'd44, 6'd42, 6'd40,
    6'd63, 6'd61, 6'd59, 6'd57, 6'd50, 6'd48, 6'd54, 6'd52,
    6'd51, 6'd49, 6'd55, 6'd53, 6'd62, 6'd60, 6'd58, 6'd56};
  // ==========================================================================
  // Registers
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_STATUS  = 8'h04;
  localparam logic [7:0]  REG_IDLE    = 8'h08;
  localparam logic [7:0]  REG_DATA    = 8'h0C;
  localparam logic [7:0]  REG_CORR    = 8'h10;
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam int          CTRL_PACK   = 0;
  localparam int          CTRL_SLOT   = 1;
  localparam int          CTRL_MODE   = 3;
  localparam int          CTRL_FHED   = 5;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {SCTF_SYNC, SCTF_IDLE, SCTF_DATA} sctf_kind_t;
endpackage

// ---- hw/sctf_lane_crc.sv ----
// One byte lane CRC-8 generator, MSB first.
// Assumes load and update come from the cell sequencer on the same clock.
`timescale 1ns/1ps
module sctf_lane_crc
  import sctf_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       load,
  input  wire logic       update,
  input  wire logic [7:0] din,
  output logic      [7:0] crc
);
  logic [7:0] crc_r;
  logic [7:0] crc_nxt;
  logic [7:0] step;

  always_comb begin
    step = crc_r;
    for (int i = 7; i >= 0; i--) begin
      step = {step[6:0], 1'b0} ^ ((step[7] ^ din[i]) ? CRC_POLY : 8'h00);
    end
    crc_nxt = crc_r;
    if (load) begin
      crc_nxt = CRC_SEED;
    end else if (update) begin
      crc_nxt = step;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      crc_r <= CRC_SEED;
    end else begin
      crc_r <= crc_nxt;
    end
  end

  assign crc = crc_r;
endmodule // sctf_lane_crc

// ---- hw/sctf_tx.sv ----
// Switch cell tx formatter: cell FIFO, sync/idle/data cell stream, lane split.
// Assumes the data mover writes 16-word logical cells, bytes big-endian:
// bytes 0-5 cell header, bytes 6-63 data. link_synced comes from the macro.
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module sctf_tx
  import sctf_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [31:0] cell_wdata,
  input  wire logic        cell_wvalid,
  output logic             cell_wready,
  input  wire logic        link_synced,
  output logic [31:0]      link_lane_out,
  output logic             link_cell_start,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // ==========================================================================
  // Link status synchroniser
  logic sync_m_r;
  logic sync_s_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_m_r <= 1'b0;
      sync_s_r <= 1'b0;
    end else begin
      sync_m_r <= link_synced;
      sync_s_r <= sync_m_r;
    end
  end

  // ==========================================================================
  // Cell FIFO, two cell slots
  logic [31:0] mem [FIFO_WORDS];
  logic [4:0]  wptr_r, wptr_nxt;
  logic [4:0]  rptr_r, rptr_nxt;
  logic [5:0]  cnt_r, cnt_nxt;
  logic        wready_r, wready_nxt;
  logic        push;
  logic        pop;

  assign push = cell_wvalid && wready_r;

  always_comb begin
    wptr_nxt = push ? wptr_r + 5'd1 : wptr_r;
    rptr_nxt = pop ? rptr_r + 5'(CELL_WORDS) : rptr_r;
    cnt_nxt  = cnt_r + (push ? 6'd1 : 6'd0) - (pop ? 6'(CELL_WORDS) : 6'd0);
    wready_nxt = cnt_nxt != 6'(FIFO_WORDS);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wptr_r   <= 5'd0;
      rptr_r   <= 5'd0;
      cnt_r    <= 6'd0;
      wready_r <= 1'b0;
    end else begin
      wptr_r   <= wptr_nxt;
      rptr_r   <= rptr_nxt;
      cnt_r    <= cnt_nxt;
      wready_r <= wready_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wptr_r] <= cell_wdata;
    end
  end

  assign cell_wready = wready_r;

  // Byte of the cell at the head of the FIFO
  function automatic logic [7:0] fbyte(input logic [5:0] b);
    logic [31:0] w;
    w = mem[rptr_r + 5'(b[5:2])];
    return w[8'(31 - 8 * b[1:0]) -: 8];
  endfunction

  // ==========================================================================
  // Control register fields
  logic [7:0] ctrl_r;
  logic       pack_en;
  logic [1:0] fh_slot;
  logic [1:0] blade_mode;
  logic       fh_edit;

  assign pack_en    = ctrl_r[CTRL_PACK];
  assign fh_slot    = ctrl_r[CTRL_SLOT +: 2];
  assign blade_mode = ctrl_r[CTRL_MODE +: 2];
  assign fh_edit    = ctrl_r[CTRL_FHED];

  // ==========================================================================
  // Header and frame header edits of a data cell
  logic [5:0] fh_base;
  logic [7:0] fh_b0, fh_b1, fh_b2;
  logic       fh_uc;
  logic [3:0] fh_fc;
  logic [7:0] qual_raw, hb1, hb2, qual_d;
  logic       qual_par;
  logic [5:0] corr_lim;
  logic       corr_bad;

  always_comb begin
    fh_base  = pack_en ? FH_BASE[fh_slot] : FH_BASE[0];
    fh_b0    = fbyte(fh_base);
    fh_b1    = fbyte(fh_base + 6'd1);
    fh_b2    = fbyte(fh_base + 6'd2);
    fh_uc    = fh_b0[FH_UC_BIT];
    fh_fc    = fh_b0[3:0];
    qual_raw = fbyte(6'd0);
    hb1      = fbyte(6'd1);
    hb2      = fbyte(6'd2);
    qual_par = ^{qual_raw[7], QUAL_DATA, qual_raw[3:0], hb1, hb2};
    qual_d   = {qual_raw[7], qual_par, QUAL_DATA, qual_raw[3:0]};
    // Unicast allows twice the multicast range; each blade mode halves it, except multicast in mode 3, where the 2-bit shift wraps to 0
    corr_lim = CORR_FULL >> (blade_mode + {1'b0, !fh_uc});
    corr_bad = fh_b2[5:0] > corr_lim;
  end

  // Correlator byte passes as sent; the source blade overlay is done on egress
  function automatic logic [7:0] edit(input logic [5:0] b, input logic [7:0] raw);
    logic [7:0] r;
    r = raw;
    if (b == 6'd0) begin
      r = qual_d;
    end else if (b == QT_BYTE && fh_edit && fh_fc == FC_ALL_ONES) begin
      r = raw | 8'h01;
    end else if (fh_edit && b == fh_base) begin
      r = {fh_uc, 3'b000, fh_fc};
    end else if (fh_edit && fh_uc && b == fh_base + 6'd1) begin
      r = {raw[7], 2'b00, raw[4:0]};
    end
    return r;
  endfunction

  // ==========================================================================
  // Cell sequencer
  sctf_kind_t kind_r, kind_nxt;
  logic [3:0] wcnt_r, wcnt_nxt;
  logic       op_r, op_nxt;
  logic       avail;
  logic [7:0] idle_h0;
  logic [7:0] lane_b [4];
  logic [7:0] crc_v [4];
  logic       crc_load;
  logic [31:0] out_nxt;
  logic        start_nxt;
  logic [31:0] out_r;
  logic        start_r;

  assign idle_h0  = {1'b0, ^{IDLE_FILL, IDLE_FILL}, QUAL_IDLE, 4'h0};
  assign crc_load = kind_r == SCTF_IDLE && wcnt_r == WORD_LAST;

  always_comb begin
    op_nxt   = op_r | sync_s_r;
    wcnt_nxt = wcnt_r + 4'd1;
    kind_nxt = kind_r;
    pop      = 1'b0;
    avail    = cnt_r >= 6'(2 * CELL_WORDS) ||
               (kind_r != SCTF_DATA && cnt_r >= 6'(CELL_WORDS));
    if (wcnt_r == WORD_LAST) begin
      pop = kind_r == SCTF_DATA;
      if (!op_nxt) begin
        kind_nxt = SCTF_SYNC;
      end else if (avail) begin
        kind_nxt = SCTF_DATA;
      end else begin
        kind_nxt = SCTF_IDLE;
      end
    end
    for (int l = 0; l < 4; l++) begin
      unique case (kind_r)
        SCTF_SYNC: lane_b[l] = SYNC_FILL;
        SCTF_IDLE: begin
          if (wcnt_r == WORD_LAST) begin
            lane_b[l] = crc_v[l];
          end else if (l == LANE_MASTER && wcnt_r == 4'd0) begin
            lane_b[l] = idle_h0;
          end else begin
            lane_b[l] = IDLE_FILL;
          end
        end
        SCTF_DATA: begin
          lane_b[l] = edit(LANE_MAP[{wcnt_r, 2'(l)}],
                           fbyte(LANE_MAP[{wcnt_r, 2'(l)}]));
        end
        default: lane_b[l] = SYNC_FILL;
      endcase
    end
    for (int l = 0; l < 4; l++) begin
      for (int k = 0; k < 4; k++) begin
        out_nxt[8 * l + k]     = lane_b[l][2 * k + 1];
        out_nxt[8 * l + 4 + k] = lane_b[l][2 * k];
      end
    end
    start_nxt = wcnt_r == 4'd0;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      kind_r  <= SCTF_SYNC;
      wcnt_r  <= 4'd0;
      op_r    <= 1'b0;
      out_r   <= 32'h0;
      start_r <= 1'b0;
    end else begin
      kind_r  <= kind_nxt;
      wcnt_r  <= wcnt_nxt;
      op_r    <= op_nxt;
      out_r   <= out_nxt;
      start_r <= start_nxt;
    end
  end

  assign link_lane_out   = out_r;
  assign link_cell_start = start_r;

  for (genvar g = 0; g < 4; g++) begin : g_crc
    sctf_lane_crc u_crc (
      .sys_clk (sys_clk),
      .rst     (rst),
      .load    (crc_load),
      .update  (!crc_load),
      .din     (lane_b[g]),
      .crc     (crc_v[g])
    );
  end

  // ==========================================================================
  // Statistics
  logic [31:0] idle_cnt_r, idle_cnt_nxt;
  logic [31:0] data_cnt_r, data_cnt_nxt;
  logic [31:0] corr_cnt_r, corr_cnt_nxt;

  always_comb begin
    idle_cnt_nxt = idle_cnt_r;
    data_cnt_nxt = data_cnt_r;
    corr_cnt_nxt = corr_cnt_r;
    if (wcnt_r == 4'd0 && kind_r == SCTF_IDLE) begin
      idle_cnt_nxt = idle_cnt_r + 32'h1;
    end
    if (wcnt_r == 4'd0 && kind_r == SCTF_DATA) begin
      data_cnt_nxt = data_cnt_r + 32'h1;
      if (fh_edit && corr_bad) begin
        corr_cnt_nxt = corr_cnt_r + 32'h1;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite slave
  logic       aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic       bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [7:0] ctrl_nxt;
  logic       do_wr;
  logic       aw_rdy_r, w_rdy_r, ar_rdy_r;

  always_comb begin
    aw_have_nxt = aw_have_r || (s_axi_awvalid && s_axi_awready);
    w_have_nxt  = w_have_r || (s_axi_wvalid && s_axi_wready);
    awaddr_nxt  = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awaddr_r;
    wdata_nxt   = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wdata_r;
    wstrb_nxt   = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wstrb_r;
    bvalid_nxt  = bvalid_r && !s_axi_bready;
    bresp_nxt   = bresp_r;
    ctrl_nxt    = ctrl_r;
    do_wr       = aw_have_r && w_have_r && !bvalid_r;
    if (do_wr) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = RESP_DECERR;
      if (awaddr_r == REG_CTRL) begin
        bresp_nxt = RESP_OKAY;
        if (wstrb_r[0]) begin
          ctrl_nxt = wdata_r[7:0];
        end
      end else if (awaddr_r inside {REG_STATUS, REG_IDLE, REG_DATA, REG_CORR}) begin
        bresp_nxt = RESP_OKAY;
      end
    end
    rvalid_nxt = rvalid_r && !s_axi_rready;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      unique case (s_axi_araddr)
        REG_CTRL:   rdata_nxt = {24'h0, ctrl_r};
        REG_STATUS: rdata_nxt = {24'h0, 2'h0, cnt_r};
        REG_IDLE:   rdata_nxt = idle_cnt_r;
        REG_DATA:   rdata_nxt = data_cnt_r;
        REG_CORR:   rdata_nxt = corr_cnt_r;
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = RESP_DECERR;
        end
      endcase
      rdata_nxt[31] = op_r;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= 32'h0;
      ctrl_r    <= CTRL_RST;
      idle_cnt_r <= 32'h0;
      data_cnt_r <= 32'h0;
      corr_cnt_r <= 32'h0;
      aw_rdy_r  <= 1'b0;
      w_rdy_r   <= 1'b0;
      ar_rdy_r  <= 1'b0;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
      ctrl_r    <= ctrl_nxt;
      idle_cnt_r <= idle_cnt_nxt;
      data_cnt_r <= data_cnt_nxt;
      corr_cnt_r <= corr_cnt_nxt;
      aw_rdy_r  <= !aw_have_nxt;
      w_rdy_r   <= !w_have_nxt;
      ar_rdy_r  <= !rvalid_nxt;
    end
  end

  // Ready flags are the registered inverse of the held state
  assign s_axi_awready = aw_rdy_r;
  assign s_axi_wready  = w_rdy_r;
  assign s_axi_arready = ar_rdy_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  // ==========================================================================
  // Assertions
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence idle_w15_s;
    kind_r == SCTF_IDLE && wcnt_r == WORD_LAST;
  endsequence

  sequence data_start_s;
    kind_r == SCTF_DATA && wcnt_r == 4'd0;
  endsequence

  sync_until_lock_a: assert property (!op_r |-> kind_r == SCTF_SYNC)
    else $error("non-sync cell before link lock");
  stream_continuous_a: assert property (wcnt_r == WORD_LAST |=> wcnt_r == 4'd0)
    else $error("cell stream not contiguous");
  crc_reload_a: assert property (idle_w15_s |=> g_crc[0].u_crc.crc_r == CRC_SEED)
    else $error("lane crc not reloaded after idle cell");
  idle_qual_a: assert property (kind_r == SCTF_IDLE && wcnt_r == 4'd0
      |=> out_r[11:8] == 4'h0 && out_r[15:12] == 4'h0)
    else $error("idle qualifier not zero");
  data_whole_a: assert property (data_start_s |-> cnt_r >= 6'(CELL_WORDS))
    else $error("data cell started without full cell");
  data_qual_a: assert property (data_start_s |=> out_r[10] && out_r[14])
    else $error("data cell indicator wrong");
  qual_parity_a: assert property (data_start_s |-> ^{lane_b[1], hb1, hb2} == 1'b0)
    else $error("header parity odd");
  idle_fill_a: assert property (kind_r == SCTF_IDLE && wcnt_r == 4'd5
      |=> out_r == {4{4'hA, 4'hA}})
    else $error("idle fill wrong");
  qt_force_a: assert property (data_start_s and (fh_edit && fh_fc == FC_ALL_ONES)
      |-> ##4 out_r[4])
    else $error("queue type bit not forced");
  fifo_bound_a: assert property (cnt_r <= 6'(FIFO_WORDS)
      && !(push && cnt_r == 6'(FIFO_WORDS)))
    else $error("fifo overfilled");
endmodule // sctf_tx

// ---- verif/sctf_link_model.sv ----
// Far side of the serial link: rebuilds lane bytes and reports sync.
// Assumes the formatter's link outputs on the same clock and reset.
`timescale 1ns/1ps
module sctf_link_model #(
  parameter int SYNC_CELLS = 3
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [31:0] link_lane_out,
  input  wire logic        link_cell_start,
  output logic             link_synced,
  output logic [31:0]      rx_word
);
  int cnt_r;
  // ==========================================================================
  // Lane rebuild; no bits are examined here, the bench compares every bit of the rebuilt word
  always_comb begin
    for (int l = 0; l < 4; l++)
      for (int k = 0; k < 4; k++) begin
        rx_word[(3-l)*8+2*k+1] = link_lane_out[8*l+k];
        rx_word[(3-l)*8+2*k]   = link_lane_out[8*l+4+k];
      end
  end
  // ==========================================================================
  // Sync reported after a few sync cells
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_r       <= 0;
      link_synced <= 1'h0;
    end else if (link_cell_start) begin
      cnt_r <= cnt_r + 1;
      if (cnt_r == SYNC_CELLS) link_synced <= 1'h1;
    end
  end
endmodule // sctf_link_model

// ---- verif/test_switch_cell_tx_formatter.sv ----
// Testbench: random cells and register traffic, link stream model.
// Assumes sctf_pkg, sctf_tx and sctf_link_model compiled before.
`timescale 1ns/1ps
module test_switch_cell_tx_formatter;
  import sctf_pkg::*;
  logic        sys_clk, rst, rst_d, cell_wvalid, cell_wready, link_synced, link_cell_start;
  logic [31:0] cell_wdata, link_lane_out, rx_word, s_axi_wdata, s_axi_rdata, e;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        op_p, dat_p, started, full_seen;
  logic [7:0]  crc [4];
  logic [7:0]  cur [64];
  logic [7:0]  cq [$];
  logic [5:0]  ctrl;
  sctf_kind_t  kind;
  int          err_total, num_checks, cyc, pos, ndata, ncorr, ncomp;
  int          seed = 32'h9923;
  logic [5:0]  cfgs [6] = '{6'h00, 6'h21, 6'h2B, 6'h35, 6'h27, 6'h0F};

  sctf_tx sctf_tx_i (.sys_clk, .rst, .cell_wdata, .cell_wvalid, .cell_wready, .link_synced,
    .link_lane_out, .link_cell_start, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  sctf_link_model #(.SYNC_CELLS(3)) sctf_link_model_i (.sys_clk, .rst, .link_lane_out,
    .link_cell_start, .link_synced, .rx_word);

  initial begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end
  // ==========================================================================
  // Compare and close
  task chk_link(input string n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask
  task chk_bus(input string n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      err_total++;
      $display("CHECK FAILED bus %s expected %h seen %h", n, x, g);
    end
  endtask
  task close_out;
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    rst_d <= rst;
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  // ==========================================================================
  // Register bus master
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, wd;
    aw = 0;
    wd = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw && wd)) begin
      @(posedge sys_clk);
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'h0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk_bus("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
  endtask
  task axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk_bus("rdata", d, s_axi_rdata);
    chk_bus("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
  endtask
  // ==========================================================================
  // Cell source and stream model
  function automatic int fh_off(input logic [5:0] c);
    return (c[0] && c[2:1] != 0) ? 16 * c[2:1] : 6;
  endfunction
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? 8'h1D : 8'h00);
    return c;
  endfunction
  task send_cells(input int n);
    logic [7:0] b [64];
    @(posedge sys_clk iff link_cell_start);
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 64; i++) b[i] = 8'($random(seed));
      if (ctrl[5] && k == 0) b[fh_off(ctrl)][3:0] = 4'hF;
      for (int w = 0; w < 16; w++) begin
        cell_wdata <= {b[4*w], b[4*w+1], b[4*w+2], b[4*w+3]};
        cell_wvalid <= 1'h1;
        do begin
          @(posedge sys_clk);
          if (!cell_wready) full_seen = 1;
        end while (cell_wready !== 1'h1);
      end
      for (int i = 0; i < 64; i++) cq.push_back(b[i]);
      ncomp++;
    end
    cell_wvalid <= 1'h0;
  endtask
  task load_cell;
    int o;
    logic uc;
    for (int i = 0; i < 64; i++) cur[i] = cq.pop_front();
    ncomp--;
    ndata++;
    o = fh_off(ctrl);
    uc = cur[o][7];
    cur[0] = {cur[0][7], 1'h0, 2'h3, cur[0][3:0]};
    cur[0][6] = ^{cur[0], cur[1], cur[2]};
    if (ctrl[5] && cur[o+2][5:0] > (63 >> (ctrl[4:3] + !uc))) ncorr++;
    if (ctrl[5]) begin
      if (cur[o][3:0] == 4'hF) cur[4][0] = 1'h1;
      cur[o] = {uc, 3'h0, cur[o][3:0]};
      if (uc) cur[o+1] = {cur[o+1][7], 2'h0, cur[o+1][4:0]};
    end
  endtask
  always @(negedge sys_clk) begin
    if (rst || rst_d) begin
      started = 0;
      op_p = 0;
      dat_p = 0;
      pos = 0;
      kind = SCTF_SYNC;
      cq.delete();
      ncomp = 0;
      for (int l = 0; l < 4; l++) crc[l] = 8'hD0;
    end else begin
      if (link_cell_start) begin
        started = 1;
        pos = 0;
        kind = !op_p ? SCTF_SYNC : dat_p ? SCTF_DATA : SCTF_IDLE;
        if (kind == SCTF_DATA) load_cell();
      end else if (started) pos++;
      if (pos == 2 && link_synced) op_p = 1;
      if (pos == 14) dat_p = ncomp > 0;
      for (int l = 0; l < 4; l++) begin
        case (kind)
          SCTF_SYNC: e[31-8*l -: 8] = 8'hA5;
          SCTF_IDLE: e[31-8*l -: 8] = pos == 15 ? crc[l] :
                       (pos == 0 && l == 1) ? {1'h0, ^16'hCCCC, 6'h00} : 8'hCC;
          default: e[31-8*l -: 8] = cur[LANE_MAP[pos*4+l]];
        endcase
      end
      chk_link("link word", e, rx_word);
      if (started) chk_link("cell length", 32'h0, {31'h0, pos > 15});
      for (int l = 0; l < 4; l++)
        crc[l] = (kind == SCTF_IDLE && pos == 15) ? 8'hD0 : crc8(crc[l], e[31-8*l -: 8]);
    end
  end
  // ==========================================================================
  // Main sequence
  initial begin
    {rst, cell_wvalid, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h1F;
    {cell_wvalid, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, full_seen} = 3'h0;
    {cell_wdata, s_axi_wdata, s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 84'h0F;
    {ctrl, ndata, ncorr, err_total, num_checks, cyc} = 0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'h0;
    axi_rd(REG_CTRL, 32'h0, 2'h0);
    axi_rd(8'h14, 32'h0, 2'h3);
    @(posedge sys_clk iff kind == SCTF_IDLE);
    axi_wr(8'h14, 32'h0, 2'h3);
    for (int c = 0; c < 6; c++) begin
      axi_wr(REG_CTRL, {26'h0, cfgs[c]}, 2'h0);
      ctrl = cfgs[c];
      axi_rd(REG_CTRL, {1'h1, 25'h0, cfgs[c]}, 2'h0);
      send_cells(c == 0 ? 3 : 2);
      @(posedge sys_clk iff (ncomp == 0 && kind == SCTF_IDLE));
    end
    axi_rd(REG_DATA, {1'h1, 31'(ndata)}, 2'h0);
    axi_rd(REG_CORR, {1'h1, 31'(ncorr)}, 2'h0);
    axi_rd(REG_STATUS, 32'h80000000, 2'h0);
    chk_bus("fifo full", 32'h1, {31'h0, full_seen});
    rst <= 1'h1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk iff kind == SCTF_IDLE);
    repeat (40) @(posedge sys_clk);
    close_out();
  end
endmodule // test_switch_cell_tx_formatter
